/* File: verilog/sms_pkg.sv */
// Constants and carrier types for the sweep marker/blank/ramp outputs
package sms_pkg;

   // ==========================================================
   // Widths and sweep modes
   // ==========================================================
   localparam int unsigned SMS_FW        = 32;  // Frequency word width
   localparam int unsigned SMS_TW        = 20;  // Sweep time width, ms
   localparam int unsigned SMS_XW        = 12;  // Ramp code width
   localparam int unsigned SMS_CW        = 14;  // Gap counter width
   localparam logic [1:0]  SMS_MODE_LIN  = 2'h0;
   localparam logic [1:0]  SMS_MODE_LOG  = 2'h1;
   localparam logic [1:0]  SMS_MODE_DISC = 2'h2;
   localparam logic [SMS_XW-1:0] SMS_X_FULL = 12'hFFF; // Full scale
   localparam logic [SMS_XW-1:0] SMS_X_ZERO = 12'h000;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned SMS_CLK_HZ     = 20_000_000;
   localparam int unsigned SMS_CYC_PER_MS = SMS_CLK_HZ / 1000;
   localparam int unsigned SMS_CYC_PER_US = SMS_CLK_HZ / 1_000_000;
   // Ramp is held at zero from this sweep time upward
   localparam int unsigned SMS_XOFF_S     = 100;
   localparam logic [SMS_TW-1:0] SMS_XOFF_MS = SMS_TW'(SMS_XOFF_S * 1000);
   // Blank high time between continuous discrete sweeps
   localparam int unsigned SMS_GAP_US     = 400;
   localparam int unsigned SMS_GAP_CYC    = SMS_GAP_US * SMS_CYC_PER_US;
   // Short blank pulse at the stop of a continuous log sweep
   localparam int unsigned SMS_PULSE_US   = 10;
   localparam int unsigned SMS_PULSE_CYC  = SMS_PULSE_US * SMS_CYC_PER_US;
   localparam logic [SMS_CW-1:0] SMS_PULSE_LOAD = SMS_CW'(SMS_PULSE_CYC - 1);

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      SMS_IDLE = 3'h0,
      SMS_UP   = 3'h1,
      SMS_DOWN = 3'h3,
      SMS_END  = 3'h2,
      SMS_GAP  = 3'h6
   } sms_state_t;

   // Sweep setup, held stable while a sweep or segment runs
   typedef struct packed {
      logic [1:0]        mode;
      logic              cont;
      logic [SMS_FW-1:0] start_f;
      logic [SMS_FW-1:0] stop_f;
      logic [SMS_FW-1:0] mark_f;
      logic [SMS_TW-1:0] time_ms;
   } sms_cfg_t;

   // Sweep engine events, each a one-cycle pulse, with current frequency
   typedef struct packed {
      logic              run_start;
      logic              down_start;
      logic              seg_start;
      logic              step;
      logic              stop_hit;
      logic              last_end;
      logic [SMS_FW-1:0] cur_f;
   } sms_evt_t;

endpackage : sms_pkg

/* File: verilog/sms_ramp.sv */
// Horizontal ramp code generator, linear in elapsed time
module sms_ramp
   import sms_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              clear,
   input  wire logic              run,
   input  wire logic [SMS_TW-1:0] time_ms,
   output logic      [SMS_XW-1:0] level
);

   logic [31:0]       period_r;
   logic [31:0]       acc_r;
   logic [31:0]       acc_sum;
   logic [SMS_XW-1:0] level_r;

   // ==========================================================
   // Ramp accumulator
   // ==========================================================
   assign acc_sum = acc_r + 32'(SMS_X_FULL);
   assign level   = level_r;

   // Sweep length in cycles, latched on clear; floor keeps one step a cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         period_r <= 32'h0000_0FFF;
      end else if (clear) begin
         if (32'(time_ms) * 32'(SMS_CYC_PER_MS) < 32'(SMS_X_FULL)) begin
            period_r <= 32'(SMS_X_FULL);
         end else begin
            period_r <= 32'(time_ms) * 32'(SMS_CYC_PER_MS);
         end
      end
   end

   // Error-term stepping: full scale spread evenly over the period
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         acc_r   <= 32'h0000_0000;
         level_r <= SMS_X_ZERO;
      end else if (run && level_r != SMS_X_FULL) begin
         if (acc_sum >= period_r) begin
            acc_r   <= acc_sum - period_r;
            level_r <= level_r + 12'h001;
         end else begin
            acc_r   <= acc_sum;
         end
      end
   end

endmodule : sms_ramp

/* File: verilog/sms_outputs.sv */
// Sweep marker, blanking and horizontal ramp outputs
module sms_outputs
   import sms_pkg::*;
#(
   parameter int unsigned GAP_CYC = SMS_GAP_CYC
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire sms_cfg_t          cfg,
   input  wire sms_evt_t          evt,
   output logic                   marker,
   output logic                   z_blank,
   output logic                   restart,
   output logic      [SMS_XW-1:0] x_drive
);

   localparam logic [SMS_CW-1:0] GAP_LOAD = SMS_CW'(GAP_CYC - 1);

   sms_state_t        state_r;
   logic [SMS_CW-1:0] cnt_r;
   logic              marker_r;
   logic              z_blank_r;
   logic              restart_r;
   logic              is_lin;
   logic              is_log;
   logic              is_disc;
   logic              seg_up;
   logic              in_span;
   logic              all_equal;
   logic              crossed;
   logic              end_evt;
   logic              gap_load;
   logic              gap_done;
   logic              x_en;
   logic              ramp_clear;
   logic              ramp_run;

   // ==========================================================
   // Decode of mode, span and crossing
   // ==========================================================
   assign is_lin  = (cfg.mode == SMS_MODE_LIN);
   assign is_log  = (cfg.mode == SMS_MODE_LOG);
   assign is_disc = (cfg.mode == SMS_MODE_DISC);
   assign seg_up  = (cfg.stop_f >= cfg.start_f);

   // Mark lies between start and stop, whichever way the span runs
   assign in_span = seg_up
      ? (cfg.mark_f >= cfg.start_f && cfg.mark_f <= cfg.stop_f)
      : (cfg.mark_f <= cfg.start_f && cfg.mark_f >= cfg.stop_f);

   assign all_equal = (cfg.start_f == cfg.stop_f)
                   && (cfg.stop_f == cfg.mark_f);

   // Frequency has reached the mark in the direction of travel
   assign crossed = evt.step && in_span
      && (seg_up ? (evt.cur_f >= cfg.mark_f)
                 : (evt.cur_f <= cfg.mark_f));

   // End of the unblanked part of a sweep, per mode
   assign end_evt = (is_lin && !cfg.cont && evt.stop_hit)
                 || (is_lin && cfg.cont && evt.down_start)
                 || (is_log && evt.stop_hit)
                 || (is_disc && evt.last_end);

   // Timed gap: blank pulse in continuous log, restart gap in continuous discrete
   assign gap_load = state_r == SMS_UP && !evt.run_start && cfg.cont
      && ((is_log && evt.stop_hit) || (is_disc && evt.last_end));
   assign gap_done = state_r == SMS_GAP && cnt_r == '0;

   // ==========================================================
   // Sweep phase tracking
   // ==========================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= SMS_IDLE;
      end else if (evt.run_start) begin
         state_r <= SMS_UP;
      end else begin
         unique case (state_r)
            SMS_UP: begin
               if (is_lin && cfg.cont && evt.down_start) begin
                  state_r <= SMS_DOWN;
               end else if (gap_load) begin
                  state_r <= SMS_GAP;
               end else if (end_evt && !cfg.cont) begin
                  state_r <= SMS_END;
               end
            end
            SMS_GAP: begin
               if (gap_done) begin
                  state_r <= is_log ? SMS_UP : SMS_IDLE;
               end
            end
            SMS_IDLE, SMS_DOWN, SMS_END: begin
               state_r <= state_r;
            end
            default: begin
               state_r <= SMS_IDLE;
            end
         endcase
      end
   end

   // Gap counter, loaded as the gap opens
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (gap_load) begin
         cnt_r <= is_log ? SMS_PULSE_LOAD : GAP_LOAD;
      end else if (state_r == SMS_GAP && cnt_r != '0) begin
         cnt_r <= cnt_r - 14'h0001;
      end
   end

   // One-cycle request to the sweep engine to begin the next pass
   always_ff @(posedge clk) begin
      if (rst) begin
         restart_r <= 1'b0;
      end else begin
         restart_r <= gap_done && is_disc;
      end
   end

   // ==========================================================
   // Marker
   // ==========================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         marker_r <= 1'b1;
      end else if (is_log) begin
         marker_r <= 1'b1;
      end else if (is_disc) begin
         if (evt.seg_start) begin
            marker_r <= !all_equal;
         end else if (crossed && !all_equal) begin
            marker_r <= 1'b0;
         end
      end else begin
         if (evt.run_start) begin
            marker_r <= 1'b1;
         end else if (evt.stop_hit) begin
            marker_r <= 1'b1;
         end else if (state_r == SMS_UP && seg_up && crossed) begin
            marker_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Blanking
   // ==========================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         z_blank_r <= 1'b1;
      end else if (evt.run_start) begin
         z_blank_r <= 1'b0;
      end else if (state_r == SMS_UP && end_evt) begin
         z_blank_r <= 1'b1;
      end else if (gap_done && is_log) begin
         z_blank_r <= 1'b0;
      end
   end

   // ==========================================================
   // Horizontal ramp
   // ==========================================================
   assign x_en = !is_disc && cfg.time_ms < SMS_XOFF_MS;

   // Reset on each new pass; held at zero on the down pass
   assign ramp_clear = !x_en || evt.run_start
                    || (is_lin && cfg.cont && evt.down_start)
                    || gap_load;
   // Advances only on an upward pass; holds full afterwards
   assign ramp_run = x_en && state_r == SMS_UP;

   sms_ramp u_ramp (
      .clk     (clk),
      .rst     (rst),
      .clear   (ramp_clear),
      .run     (ramp_run),
      .time_ms (cfg.time_ms),
      .level   (x_drive)
   );

   assign marker  = marker_r;
   assign z_blank = z_blank_r;
   assign restart = restart_r;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_gap_open;
      is_disc && cfg.cont && state_r == SMS_UP && evt.last_end
         && !evt.run_start;
   endsequence

   sequence s_gap_hold;
      z_blank_r [*8];
   endsequence

   a_log_marker_idle: assert property (
      is_log |=> marker_r)
      else $error("marker moved during log sweep");

   a_lin_mark_low: assert property (
      is_lin && state_r == SMS_UP && crossed && seg_up
         && !evt.run_start && !evt.stop_hit |=> !marker_r)
      else $error("marker missed the linear mark");

   a_lin_stop_high: assert property (
      is_lin && evt.stop_hit |=> marker_r)
      else $error("marker not high at stop");

   a_down_no_mark: assert property (
      is_lin && state_r == SMS_DOWN && !evt.run_start
         |=> $stable(marker_r))
      else $error("marker moved on down pass");

   a_span_no_mark: assert property (
      is_lin && !in_span && !evt.run_start && $stable(cfg)
         && marker_r |=> marker_r)
      else $error("marker moved with mark out of span");

   a_seg_equal_low: assert property (
      is_disc && evt.seg_start && all_equal |=> !marker_r)
      else $error("equal segment marker not low");

   a_seg_span_high: assert property (
      is_disc && evt.seg_start && !in_span |=> marker_r)
      else $error("out of span segment marker not high");

   a_seg_down_mark: assert property (
      is_disc && crossed && !seg_up && !evt.seg_start && !all_equal
         |=> !marker_r)
      else $error("down segment mark missed");

   a_blank_start: assert property (
      evt.run_start |=> !z_blank_r)
      else $error("blank not low at sweep start");

   a_gap_blank: assert property (
      s_gap_open |=> s_gap_hold)
      else $error("blank gap too short");

   a_x_disabled: assert property (
      !x_en |-> ##1 x_drive == SMS_X_ZERO)
      else $error("ramp not held at zero");

   a_x_down_zero: assert property (
      is_lin && state_r == SMS_DOWN |-> x_drive == SMS_X_ZERO)
      else $error("ramp not zero on down pass");

   // Blanking levels per mode and phase, and restart pulse width
   a_cont_down_blank: assert property (
      is_lin && cfg.cont && state_r == SMS_UP && evt.down_start
         && !evt.run_start |=> z_blank_r)
      else $error("blank not high on down pass");

   a_pass_blank_low: assert property (
      state_r == SMS_UP && !end_evt && !z_blank_r |=> !z_blank_r)
      else $error("blank rose during a pass");

   a_log_stop_blank: assert property (
      is_log && state_r == SMS_UP && evt.stop_hit && !evt.run_start
         |=> z_blank_r)
      else $error("blank not high at log stop");

   sequence s_pulse_open;
      is_log && cfg.cont && state_r == SMS_UP && evt.stop_hit
         && !evt.run_start;
   endsequence

   sequence s_pulse_high;
      z_blank_r ##199 z_blank_r ##1 !z_blank_r;
   endsequence

   a_log_blank_pulse: assert property (
      s_pulse_open |=> s_pulse_high)
      else $error("log blank pulse wrong length");

   a_disc_last_blank: assert property (
      is_disc && state_r == SMS_UP && evt.last_end && !evt.run_start
         |=> z_blank_r)
      else $error("blank not high after last segment");

   a_restart_pulse: assert property (
      restart_r |=> !restart_r)
      else $error("restart longer than one cycle");

   // Marker steps
   a_lin_start_high: assert property (
      is_lin && evt.run_start |=> marker_r)
      else $error("marker not high at sweep start");

   a_lin_no_early: assert property (
      is_lin && state_r == SMS_UP && evt.step && seg_up && marker_r
         && evt.cur_f < cfg.mark_f && !evt.run_start && !evt.stop_hit
         |=> marker_r)
      else $error("marker fell before the mark");

   a_seg_start_high: assert property (
      is_disc && evt.seg_start && !all_equal |=> marker_r)
      else $error("marker not high at segment start");

   a_seg_low_hold: assert property (
      is_disc && !marker_r && !evt.seg_start |=> !marker_r)
      else $error("marker rose inside a segment");

   // Ramp shape
   a_x_rise_only: assert property (
      !ramp_clear |=> x_drive >= $past(x_drive))
      else $error("ramp fell without a clear");

   a_x_end_hold: assert property (
      state_r == SMS_END && !ramp_clear |=> $stable(x_drive))
      else $error("ramp moved after sweep end");

   a_x_disc_zero: assert property (
      is_disc |=> x_drive == SMS_X_ZERO)
      else $error("ramp moved during discrete sweep");

endmodule : sms_outputs

/* File: bench/sms_display.sv */
// Plotter model that draws the sweep outputs while the pen is down
module sms_display
   import sms_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              marker,
   input  wire logic              z_blank,
   input  wire logic [SMS_XW-1:0] x_drive,
   output logic      [7:0]        pen_marks,
   output logic      [SMS_XW-1:0] pen_x
);
   timeunit 1ns;
   timeprecision 1ps;

   logic marker_r;

   // Pen follows the ramp only while unblanked; marker falls become ticks
   always_ff @(posedge clk) begin
      marker_r <= marker;
      if (rst) begin
         pen_marks <= 8'h00;
         pen_x     <= SMS_X_ZERO;
      end else if (!z_blank) begin
         pen_x <= x_drive;
         if (marker_r && !marker) begin
            pen_marks <= pen_marks + 8'h01;
         end
      end
   end
endmodule : sms_display

/* File: bench/sms_outputs_bench.sv */
// Self-checking bench for the sweep marker, blank and ramp outputs
module sms_outputs_bench
   import sms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals
   // ==========================================================
   localparam int         GAP  = 20;
   localparam logic [5:0] RUN  = 6'h20;
   localparam logic [5:0] DOWN = 6'h10;
   localparam logic [5:0] SEG  = 6'h08;
   localparam logic [5:0] STEP = 6'h04;
   localparam logic [5:0] STOP = 6'h02;
   localparam logic [5:0] LAST = 6'h01;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   sms_cfg_t          cfg = '0;
   sms_evt_t          evt = '0;
   logic              marker;
   logic              z_blank;
   logic              restart;
   logic [SMS_XW-1:0] x_drive;
   logic [7:0]        pen_marks;
   logic [SMS_XW-1:0] pen_x;
   int                fail_count  = 0;
   int                check_count = 0;
   int                cyc         = 0;

   sms_outputs #(.GAP_CYC(GAP)) dut_u (
      .clk(clk), .rst(rst), .cfg(cfg), .evt(evt), .marker(marker),
      .z_blank(z_blank), .restart(restart), .x_drive(x_drive));
   sms_display disp_u (
      .clk(clk), .rst(rst), .marker(marker), .z_blank(z_blank),
      .x_drive(x_drive), .pen_marks(pen_marks), .pen_x(pen_x));

   // 20 MHz clock
   always #25 clk = ~clk;

   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic end_of_test();
      if (fail_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   task automatic chk1(input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask : chk1

   task automatic chkx(input logic [SMS_XW-1:0] e, input logic [SMS_XW-1:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask : chkx

   // Wait n cycles, ending just after an edge
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   // One-cycle event pulse, then one settling cycle
   task automatic go(input logic [5:0] k, input logic [SMS_FW-1:0] f);
      evt = {k, f};
      @(posedge clk);
      #1 evt = '0;
      idle(1);
   endtask : go

   task automatic setc(input logic [1:0] m, input logic c, input int a,
                       input int b, input int k, input int t);
      cfg = '{mode: m, cont: c, start_f: SMS_FW'(a),
              stop_f: SMS_FW'(b), mark_f: SMS_FW'(k),
              time_ms: SMS_TW'(t)};
   endtask : setc

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic s_lin_single();
      setc(SMS_MODE_LIN, 1'b0, 100, 200, 150, 1);
      go(RUN, 0);
      chk1(1'b0, z_blank);
      chk1(1'b1, marker);
      go(STEP, 149);
      chk1(1'b1, marker);
      go(STEP, 150);
      chk1(1'b0, marker);
      idle(10000);
      chk1(1'b1, x_drive > 12'h700 && x_drive < 12'h900);
      idle(11000);
      go(STOP, 0);
      chk1(1'b1, marker);
      chk1(1'b1, z_blank);
      idle(30);
      chkx(SMS_X_FULL, x_drive);
      chkx(SMS_X_FULL, pen_x);
      chk1(1'b1, z_blank);
      chk1(1'b1, pen_marks == 8'h01);
   endtask : s_lin_single

   task automatic s_lin_out();
      setc(SMS_MODE_LIN, 1'b0, 100, 200, 300, 1);
      go(RUN, 0);
      go(STEP, 150);
      go(STEP, 200);
      chk1(1'b1, marker);
      go(STOP, 0);
   endtask : s_lin_out

   task automatic s_lin_cont();
      setc(SMS_MODE_LIN, 1'b1, 100, 200, 150, 1);
      go(RUN, 0);
      idle(100);
      chk1(1'b0, z_blank);
      chk1(1'b1, x_drive != SMS_X_ZERO);
      go(STOP, 0);
      go(DOWN, 0);
      chk1(1'b1, z_blank);
      chkx(SMS_X_ZERO, x_drive);
      go(STEP, 150);
      go(STEP, 120);
      chk1(1'b1, marker);
      idle(20);
      chkx(SMS_X_ZERO, x_drive);
      go(RUN, 0);
      chk1(1'b0, z_blank);
   endtask : s_lin_cont

   task automatic s_log();
      setc(SMS_MODE_LOG, 1'b0, 100, 200, 150, 1);
      go(RUN, 0);
      chk1(1'b0, z_blank);
      go(STEP, 160);
      chk1(1'b1, marker);
      idle(50);
      chk1(1'b1, x_drive != SMS_X_ZERO);
      go(STOP, 0);
      idle(300);
      chk1(1'b1, z_blank);
      setc(SMS_MODE_LOG, 1'b1, 100, 200, 150, 1);
      go(RUN, 0);
      go(STOP, 0);
      chk1(1'b1, z_blank);
      idle(210);
      chk1(1'b0, z_blank);
   endtask : s_log

   task automatic s_disc();
      int n;
      setc(SMS_MODE_DISC, 1'b1, 100, 200, 150, 1);
      go(RUN | SEG, 0);
      chk1(1'b0, z_blank);
      chk1(1'b1, marker);
      go(STEP, 150);
      go(STEP, 180);
      chk1(1'b0, marker);
      chkx(SMS_X_ZERO, x_drive);
      setc(SMS_MODE_DISC, 1'b1, 200, 100, 150, 1);
      go(SEG, 0);
      chk1(1'b1, marker);
      go(STEP, 140);
      chk1(1'b0, marker);
      setc(SMS_MODE_DISC, 1'b1, 100, 200, 300, 1);
      go(SEG, 0);
      go(STEP, 200);
      chk1(1'b1, marker);
      chk1(1'b0, z_blank);
      setc(SMS_MODE_DISC, 1'b1, 100, 100, 100, 1);
      go(SEG, 0);
      chk1(1'b0, marker);
      go(LAST, 0);
      n = 0;
      while (restart !== 1'b1 && n < 100) begin
         chk1(1'b1, z_blank);
         idle(1);
         n++;
      end
      chk1(1'b1, n >= GAP - 2 && n <= GAP);
      go(RUN | SEG, 0);
      chk1(1'b0, z_blank);
   endtask : s_disc

   task automatic s_ramp_off();
      setc(SMS_MODE_LIN, 1'b0, 100, 200, 150, 100000);
      go(RUN, 0);
      idle(100);
      chkx(SMS_X_ZERO, x_drive);
      go(STOP, 0);
   endtask : s_ramp_off

   // ==========================================================
   // Main sequence and timeout
   // ==========================================================
   initial begin
      idle(4);
      rst = 1'b0;
      idle(1);
      s_lin_single();
      s_lin_out();
      s_lin_cont();
      s_log();
      s_disc();
      s_ramp_off();
      end_of_test();
   end

   // Cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         end_of_test();
      end
   end
endmodule : sms_outputs_bench
